// ---- hw/wwd_top.sv ----
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "wwd_cfg.svh"
module wwd_top
  import wwd_pkg::*;
#(
  parameter int CNT_W = 12,
  parameter int PSC_W = 3
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic slow_internal_oscillator,
  input wire logic debug_halt,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic sys_reset_req,
  output logic irq
);
  wwd_bus_t bus;
  wwd_mode_t mode;
  wwd_state_t state;
  wwd_state_t next_state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] reload_val;
  logic [CNT_W-1:0] delta_val;
  logic prot_on;
  logic [`WWD_EVENTS-1:0] status;
  logic [`WWD_EVENTS-1:0] mask;
  logic tick;
  wwd_mode_t next_mode;
  logic [CNT_W-1:0] next_reload_val;
  logic [CNT_W-1:0] next_delta_val;
  logic next_prot_on;
  logic [`WWD_EVENTS-1:0] next_status;
  logic [`WWD_EVENTS-1:0] next_mask;
  logic [31:0] next_rdata;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // address decode
  wire sel_ctrl = (bus.addr == `WWD_OFS_CTRL);
  wire sel_mode = (bus.addr == `WWD_OFS_MODE);
  wire sel_reload = (bus.addr == `WWD_OFS_RELOAD);
  wire sel_delta = (bus.addr == `WWD_OFS_DELTA);
  wire sel_prot = (bus.addr == `WWD_OFS_PROT);
  wire sel_count = (bus.addr == `WWD_OFS_COUNT);
  wire sel_status = (bus.addr == `WWD_OFS_STATUS);
  wire sel_mask = (bus.addr == `WWD_OFS_MASK);

  // configuration writes are dropped silently while locked
  wire cfg_wr_ok = bus.wr & ~prot_on;
  wire wr_mode = cfg_wr_ok & sel_mode;
  wire wr_reload = cfg_wr_ok & sel_reload;
  wire wr_delta = cfg_wr_ok & sel_delta;
  wire wr_prot = bus.wr & sel_prot;
  wire wr_ctrl = bus.wr & sel_ctrl;
  wire wr_status = bus.wr & sel_status;
  wire wr_mask = bus.wr & sel_mask;

  wire key_ok = (bus.wdata[15:0] == `WWD_RELOAD_KEY);
  wire running = (state == WWD_RUN);
  wire reload_req = wr_ctrl & key_ok & running;
  wire bad_key = wr_ctrl & ~key_ok & running;
  // still above the delta value means the window has not opened
  wire early = reload_req & (count > delta_val);
  wire good_reload = reload_req & ~early;
  // debug freeze only when software asked for it
  wire frozen = mode.dbg_stop & debug_halt;
  wire underflow = running & tick & (count == '0);
  wire fire = underflow | early;

  wwd_prescaler #(
    .PSC_W(PSC_W)
  ) u_psc (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .slow_internal_oscillator(slow_internal_oscillator),
    .run(running & ~frozen),
    .restart(good_reload | ~running),
    .prescale(mode.prescale),
    .tick(tick)
  );

  // counter: reload wins over a coincident tick
  always_comb begin
    next_count = count;
    if (!running) begin
      next_count = reload_val;
    end else if (good_reload) begin
      next_count = reload_val;
    end else if (underflow) begin
      next_count = reload_val;
    end else if (tick) begin
      next_count = count - 1'b1;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      WWD_IDLE: begin
        if (mode.enable) begin
          next_state = WWD_RUN;
        end
      end
      WWD_RUN: begin
        if (fire) begin
          next_state = WWD_FIRE;
        end else if (!mode.enable) begin
          next_state = WWD_IDLE;
        end
      end
      WWD_FIRE: begin
        // one request pulse, then carry on until the system reset lands
        next_state = mode.enable ? WWD_RUN : WWD_IDLE;
      end
      default: begin
        next_state = WWD_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= WWD_IDLE;
      count <= `WWD_RELOAD_RST;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign sys_reset_req = (state == WWD_FIRE);

  // configuration next values; a locked write never reaches mode, reload or delta
  assign next_mode = wr_mode ? wwd_mode_t'{
    dbg_stop: bus.wdata[`WWD_MODE_DBG_BIT],
    prescale: bus.wdata[`WWD_MODE_PSC_LSB +: PSC_W],
    enable: bus.wdata[`WWD_MODE_EN_BIT]
  } : mode;
  assign next_reload_val = wr_reload ? bus.wdata[CNT_W-1:0] : reload_val;
  assign next_delta_val = wr_delta ? bus.wdata[CNT_W-1:0] : delta_val;
  // lock is open from reset, and afterwards only while the unlock key was the last value written
  assign next_prot_on = wr_prot ? (bus.wdata[15:0] != `WWD_UNLOCK_KEY) : prot_on;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode <= '{dbg_stop: 1'b0, prescale: `WWD_PSC_RST, enable: 1'b0};
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reload_val <= `WWD_RELOAD_RST;
      delta_val <= `WWD_DELTA_RST;
    end else begin
      reload_val <= next_reload_val;
      delta_val <= next_delta_val;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prot_on <= 1'b0;
    end else begin
      prot_on <= next_prot_on;
    end
  end

  // sticky events; a set in the same cycle as its clear survives
  wire [`WWD_EVENTS-1:0] ev_set = {bad_key, early, underflow};
  wire [`WWD_EVENTS-1:0] ev_clr = wr_status ? bus.wdata[`WWD_EVENTS-1:0] : '0;

  for (genvar i = 0; i < `WWD_EVENTS; i++) begin : g_event
    assign next_status[i] = ev_set[i] | (status[i] & ~ev_clr[i]);
    assign next_mask[i] = wr_mask ? bus.wdata[i] : mask[i];
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      status <= '0;
      mask <= '0;
    end else begin
      status <= next_status;
      mask <= next_mask;
    end
  end

  assign irq = |(status & mask);

  // read mux; unmapped addresses return zero
  wire [31:0] rd_mode = {27'h0, mode.dbg_stop, mode.prescale, mode.enable};
  wire [31:0] rd_reload = {20'h0, reload_val};
  wire [31:0] rd_delta = {20'h0, delta_val};
  wire [31:0] rd_prot = {31'h0, prot_on};
  wire [31:0] rd_count = {20'h0, count};
  wire [31:0] rd_status = {29'h0, status};
  wire [31:0] rd_mask = {29'h0, mask};
  wire [31:0] rd_mux = sel_mode ? rd_mode :
                       sel_reload ? rd_reload :
                       sel_delta ? rd_delta :
                       sel_prot ? rd_prot :
                       sel_count ? rd_count :
                       sel_status ? rd_status :
                       sel_mask ? rd_mask : 32'h0;
  assign next_rdata = bus.rd ? rd_mux : 32'h0;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
endmodule : wwd_top
`default_nettype wire

// ---- hw/wwd_cfg.svh ----
`ifndef WWD_CFG_SVH
`define WWD_CFG_SVH

`define WWD_ADDR_W 8
`define WWD_OFS_CTRL 8'h00
`define WWD_OFS_MODE 8'h04
`define WWD_OFS_RELOAD 8'h08
`define WWD_OFS_DELTA 8'h0c
`define WWD_OFS_PROT 8'h10
`define WWD_OFS_COUNT 8'h14
`define WWD_OFS_STATUS 8'h18
`define WWD_OFS_MASK 8'h1c

`define WWD_RELOAD_KEY 16'h5fa0
`define WWD_UNLOCK_KEY 16'h35ca

`define WWD_MODE_EN_BIT 0
`define WWD_MODE_PSC_LSB 1
`define WWD_MODE_DBG_BIT 4

`define WWD_ST_UNDERFLOW 0
`define WWD_ST_EARLY 1
`define WWD_ST_BADKEY 2
`define WWD_EVENTS 3

`define WWD_RELOAD_RST 12'hfff
`define WWD_DELTA_RST 12'hfff
`define WWD_PSC_RST 3'h0

`endif

// ---- hw/wwd_pkg.sv ----
package wwd_pkg;

  typedef struct packed {
    logic dbg_stop;
    logic [2:0] prescale;
    logic enable;
  } wwd_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } wwd_bus_t;

  typedef enum logic [2:0] {
    WWD_IDLE = 3'b001,
    WWD_RUN = 3'b010,
    WWD_FIRE = 3'b100
  } wwd_state_t;

endpackage : wwd_pkg

// ---- hw/wwd_prescaler.sv ----
`timescale 1ns/10ps
`default_nettype none
module wwd_prescaler #(
  parameter int PSC_W = 3
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic slow_internal_oscillator,
  input wire logic run,
  input wire logic restart,
  input wire logic [PSC_W-1:0] prescale,
  output logic tick
);
  localparam int DIV_W = (1 << PSC_W) - 1;

  logic osc_meta;
  logic osc_sync;
  logic osc_prev;
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  wire osc_rise = osc_sync & ~osc_prev;
  // divide by two to the power of the setting
  wire [DIV_W-1:0] div_max = DIV_W'((1 << prescale) - 1);
  wire div_wrap = (div_cnt >= div_max);
  wire step = run & osc_rise & ~restart;

  assign next_div_cnt = (restart | (step & div_wrap)) ? '0 : (step ? div_cnt + 1'b1 : div_cnt);

  // oscillator is asynchronous to core_clk, so two flops before use
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
      div_cnt <= '0;
      tick <= 1'b0;
    end else begin
      osc_meta <= slow_internal_oscillator;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
      div_cnt <= next_div_cnt;
      tick <= step & div_wrap;
    end
  end
endmodule : wwd_prescaler
`default_nettype wire

// ---- testbench/wwd_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module wwd_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic slow_internal_oscillator,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic sys_reset_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // cycles since the slow clock last rose
  logic osc_q;
  logic [3:0] since;
  always_ff @(posedge core_clk) begin
    osc_q <= slow_internal_oscillator;
    if (!rst_n) since <= 4'hf;
    else if (slow_internal_oscillator && !osc_q) since <= 4'h0;
    else if (since != 4'hf) since <= since + 4'h1;
  end
  sequence rd_at(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  cnt_width_a: assert property (rd_at(8'h14) |=> reg_rdata[31:12] == 0)
    else $error("count wider than 12 bits");
  rst_pulse_a: assert property (sys_reset_req |=> !sys_reset_req)
    else $error("reset request too long");
  delta_width_a: assert property (rd_at(8'h0c) |=> reg_rdata[31:12] == 0)
    else $error("delta wider than 12 bits");
  mode_bits_a: assert property (rd_at(8'h04) |=> reg_rdata[31:5] == 0)
    else $error("mode upper bits set");
  prot_bits_a: assert property (rd_at(8'h10) |=> reg_rdata[31:1] == 0)
    else $error("protect upper bits set");
  osc_cause_a: assert property (sys_reset_req && !$past(reg_wr) |-> since < 4'ha)
    else $error("reset without slow tick");
  ctrl_read_a: assert property (rd_at(8'h00) |=> reg_rdata == 0)
    else $error("control reads nonzero");
endmodule : wwd_checker
bind wwd_top wwd_checker chk_i (.core_clk(core_clk), .rst_n(rst_n),
  .slow_internal_oscillator(slow_internal_oscillator), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_reset_req(sys_reset_req));
`default_nettype wire

// ---- testbench/wwd_top_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module wwd_top_tb;
  logic core_clk = 0, rst_n = 0, osc = 0, halt = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic sys_reset_req, irq;
  int n_mismatch = 0, num_checks = 0, fires = 0;
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (sys_reset_req === 1'b1) fires <= fires + 1;
  wwd_top dut (.core_clk(core_clk), .rst_n(rst_n), .slow_internal_oscillator(osc), .debug_halt(halt),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sys_reset_req(sys_reset_req), .irq(irq));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, reg_rdata);
  endtask : rd
  // slow pulses, then room for the sync and tick latency
  task pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge core_clk);
      osc <= 1'b1;
      repeat (4) @(posedge core_clk);
      osc <= 1'b0;
    end
    repeat (6) @(posedge core_clk);
  endtask : pulses
  task t_reset;
    rd(8'h04, 32'h0);
    rd(8'h08, 32'hfff);
    rd(8'h0c, 32'hfff);
    rd(8'h14, 32'hfff);
    rd(8'h18, 32'h0);
    rd(8'h1c, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h40, 32'h0);
  endtask : t_reset
  task t_underflow;
    wr(8'h08, 32'h3);
    rd(8'h14, 32'h3);
    wr(8'h04, 32'h1);
    pulses(3);
    rd(8'h14, 32'h0);
    chk("fires", 0, fires);
    pulses(1);
    chk("fires", 1, fires);
    rd(8'h14, 32'h3);
    rd(8'h18, 32'h1);
    chk("irq", 0, irq);
    wr(8'h1c, 32'h7);
    #1 chk("irq", 1, irq);
    wr(8'h18, 32'h1);
    #1 chk("irq", 0, irq);
  endtask : t_underflow
  task t_window;
    wr(8'h0c, 32'h1);
    pulses(2);
    wr(8'h00, 32'h5fa0);
    #1 chk("rst", 0, sys_reset_req);
    rd(8'h14, 32'h3);
    wr(8'h00, 32'h5fa0);
    #1 chk("rst", 1, sys_reset_req);
    rd(8'h18, 32'h2);
    wr(8'h00, 32'h1234);
    rd(8'h18, 32'h6);
    wr(8'h18, 32'h7);
    rd(8'h18, 32'h0);
  endtask : t_window
  task t_protect;
    wr(8'h10, 32'h0);
    rd(8'h10, 32'h1);
    wr(8'h0c, 32'hfff);
    rd(8'h0c, 32'h1);
    wr(8'h04, 32'h0);
    rd(8'h04, 32'h1);
    wr(8'h10, 32'h35ca);
    rd(8'h10, 32'h0);
    wr(8'h0c, 32'hfff);
    rd(8'h0c, 32'hfff);
  endtask : t_protect
  task t_freeze;
    wr(8'h04, 32'h13);
    wr(8'h00, 32'h5fa0);
    @(posedge core_clk) halt <= 1'b1;
    pulses(3);
    rd(8'h14, 32'h3);
    @(posedge core_clk) halt <= 1'b0;
    pulses(4);
    rd(8'h14, 32'h1);
    // half a prescale period, then a reload must restart the divider
    pulses(1);
    wr(8'h00, 32'h5fa0);
    pulses(1);
    rd(8'h14, 32'h3);
    // freeze option off: a halt must not stop the count
    wr(8'h04, 32'h3);
    @(posedge core_clk) halt <= 1'b1;
    pulses(2);
    @(posedge core_clk) halt <= 1'b0;
    rd(8'h14, 32'h2);
  endtask : t_freeze
  // reset in mid-run must bring back every reset value
  task t_rerun;
    wr(8'h10, 32'h0);
    @(posedge core_clk) rst_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    chk("irq", 0, irq);
    chk("rst", 0, sys_reset_req);
  endtask : t_rerun
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_underflow();
    t_window();
    t_protect();
    t_freeze();
    t_rerun();
    stop_test();
  end
  // far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
endmodule : wwd_top_tb
`default_nettype wire
